/* File: design/sesu_pkg.sv */
/*
  Package for the standard event status unit: command codes, carrier
  structs, event register field positions, reset values and the
  identification string.
  Assumes a command parser upstream that decodes host commands into
  one sesu_cmd_t per accepted command.
*/
package sesu_pkg;

  // Event register field positions
  localparam int unsigned EVR_OPC_BIT  = 0;
  localparam int unsigned EVR_DDE_BIT  = 3;
  localparam int unsigned EVR_EXE_BIT  = 4;
  localparam int unsigned EVR_CME_BIT  = 5;
  localparam int unsigned EVR_PON_BIT  = 7;
  // Status byte bit that summarises the event register
  localparam int unsigned SRE_ESB_BIT  = 5;

  // Bits that exist in the event register; the others read zero
  localparam logic [7:0] EVR_USED_MASK = 8'hb9;
  // Power-on leaves only the power-on bit set
  localparam logic [7:0] EVR_RESET     = 8'h80;
  localparam logic [7:0] ESE_RESET     = 8'h00;
  localparam logic [7:0] SRE_RESET     = 8'h00;
  // Answer given by the completion query
  localparam logic [7:0] OPC_ANSWER    = 8'h01;

  // Identification string, arbitrary neutral values, first char in MSBs
  localparam int unsigned IDN_LEN      = 24;
  localparam logic [8*IDN_LEN-1:0] IDN_STR = "MAKER,MODEL0,SN000000,V1";

  // Decoded host commands
  typedef enum logic [3:0] {
    SESU_CLS,
    SESU_ESE_WR,
    SESU_ESE_RD,
    SESU_EVR_RD,
    SESU_IDN_RD,
    SESU_OPC_WR,
    SESU_OPC_RD,
    SESU_RST,
    SESU_SRE_WR,
    SESU_SRE_RD
  } sesu_op_t;

  // One command with its argument
  typedef struct packed {
    sesu_op_t   op;
    logic [7:0] arg;
  } sesu_cmd_t;

  // One-cycle event pulses from the rest of the instrument
  typedef struct packed {
    logic op_done;   // All pending operations finished
    logic dev_err;   // Device dependent error
    logic exec_err;  // Execution error
    logic cmd_err;   // Command error
  } sesu_evt_t;

endpackage

/* File: design/sesu_top.sv */
/*
  Standard event status unit: event register with clear-on-read,
  event enable mask, service request summary, completion handshake,
  identification answer and global reset / clear status strobes.
  Assumes commands and events synchronous to clk; answers leave as a
  byte stream with valid/ready toward the interface formatter.
*/
`timescale 1ns/1ps
module sesu_top (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // Command port
  input  wire logic              cmd_valid,
  input  wire sesu_pkg::sesu_cmd_t cmd,
  output logic                   cmd_ready,
  // Instrument events
  input  wire sesu_pkg::sesu_evt_t evt,
  // Answer stream
  output logic                   rsp_valid,
  output logic [7:0]             rsp_data,
  output logic                   rsp_last,
  input  wire logic              rsp_ready,
  // Status outputs and strobes
  output logic                   srq,
  output logic                   esb,
  output logic                   global_reset,
  output logic                   clear_status
);
  import sesu_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_OPC_WAIT, ST_SEND} sesu_state_t;

  logic        rst_meta_q;    // Reset release, first stage
  logic        rst_n_q;       // Reset release, used copy
  logic [7:0]  evreg_q;       // Event register
  logic [7:0]  evreg_d;       // Next event register
  logic [7:0]  ese_q;         // Event enable mask
  logic [7:0]  sre_q;         // Service request enable
  logic [7:0]  set_bits;      // Events arriving this cycle
  sesu_state_t st_q;          // Answer state
  logic [7:0]  rsp_data_q;    // Answer byte
  logic        rsp_valid_q;   // Answer byte pending
  logic        rsp_last_q;    // Final answer byte
  logic [4:0]  idn_idx_q;     // Next identification byte
  logic        srq_q;         // Service request
  logic        esb_q;         // Event summary
  logic        grst_q;        // Global reset strobe
  logic        cls_q;         // Clear status strobe
  logic        take;          // Command accepted
  logic        evreg_rd;      // Event register read accepted
  logic        cls_cmd;       // Clear status accepted

  // Reset release through two flops
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Commands taken only while no answer is busy
  assign cmd_ready = (st_q == ST_IDLE);
  assign take      = cmd_valid && cmd_ready;
  assign evreg_rd  = take && (cmd.op == SESU_EVR_RD);
  assign cls_cmd   = take && (cmd.op == SESU_CLS);

  // Event sources mapped to their bit positions
  always_comb
  begin
    set_bits = 8'h00;
    set_bits[EVR_OPC_BIT] = evt.op_done;
    set_bits[EVR_DDE_BIT] = evt.dev_err;
    set_bits[EVR_EXE_BIT] = evt.exec_err;
    set_bits[EVR_CME_BIT] = evt.cmd_err;
  end

  // Next event value: clears first, arriving events win
  always_comb
  begin
    evreg_d = evreg_q;
    if (evreg_rd || cls_cmd)
      evreg_d = 8'h00;
    else if (take && cmd.op == SESU_OPC_WR)
      evreg_d[EVR_OPC_BIT] = 1'b0;
    evreg_d = (evreg_d | set_bits) & EVR_USED_MASK;
  end

  // Event register; reset value marks power-on
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      evreg_q <= EVR_RESET;
    else
      evreg_q <= evreg_d;
  end

  // Enable masks written by command
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      ese_q <= ESE_RESET;
      sre_q <= SRE_RESET;
    end
    else
    begin
      if (take && cmd.op == SESU_ESE_WR)
        ese_q <= cmd.arg;
      if (take && cmd.op == SESU_SRE_WR)
        sre_q <= cmd.arg;
    end
  end

  // Summary and request from masked events
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      esb_q <= 1'b0;
      srq_q <= 1'b0;
    end
    else
    begin
      esb_q <= |(evreg_q & ese_q);
      srq_q <= (|(evreg_q & ese_q)) && sre_q[SRE_ESB_BIT];
    end
  end

  // Strobes to the rest of the instrument
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      grst_q <= 1'b0;
      cls_q  <= 1'b0;
    end
    else
    begin
      grst_q <= take && (cmd.op == SESU_RST);
      cls_q  <= cls_cmd;
    end
  end

  // Answer sequencer
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      st_q        <= ST_IDLE;
      rsp_valid_q <= 1'b0;
      rsp_last_q  <= 1'b0;
      rsp_data_q  <= 8'h00;
      idn_idx_q   <= 5'h00;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
        begin
          if (take)
          begin
            case (cmd.op)
              // Single-byte reads; event value cleared in the same edge
              SESU_EVR_RD, SESU_ESE_RD, SESU_SRE_RD:
              begin
                rsp_data_q  <= (cmd.op == SESU_EVR_RD) ? evreg_q :
                               (cmd.op == SESU_ESE_RD) ? ese_q : sre_q;
                rsp_valid_q <= 1'b1;
                rsp_last_q  <= 1'b1;
                st_q        <= ST_SEND;
              end
              // Wait for completion before answering
              SESU_OPC_RD:
                st_q <= ST_OPC_WAIT;
              // Stream the identification string
              SESU_IDN_RD:
              begin
                rsp_data_q  <= IDN_STR[8*IDN_LEN-1 -: 8];
                rsp_valid_q <= 1'b1;
                rsp_last_q  <= 1'b0;
                idn_idx_q   <= 5'h01;
                st_q        <= ST_SEND;
              end
              default:
                st_q <= ST_IDLE;
            endcase
          end
        end
        // Never answer zero; stall until flag is one
        ST_OPC_WAIT:
        begin
          if (evreg_q[EVR_OPC_BIT])
          begin
            rsp_data_q  <= OPC_ANSWER;
            rsp_valid_q <= 1'b1;
            rsp_last_q  <= 1'b1;
            st_q        <= ST_SEND;
          end
        end
        // Byte held until taken; next string byte, or idle after the last
        ST_SEND:
        begin
          if (rsp_ready)
          begin
            if (rsp_last_q)
            begin
              rsp_valid_q <= 1'b0;
              rsp_last_q  <= 1'b0;
              st_q        <= ST_IDLE;
            end
            else
            begin
              rsp_data_q <= IDN_STR[8*(IDN_LEN-1-32'(idn_idx_q)) +: 8];
              rsp_last_q <= (32'(idn_idx_q) == IDN_LEN-1);
              idn_idx_q  <= idn_idx_q + 5'h01;
            end
          end
        end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  assign rsp_valid    = rsp_valid_q;
  assign rsp_data     = rsp_data_q;
  assign rsp_last     = rsp_last_q;
  assign srq          = srq_q;
  assign esb          = esb_q;
  assign global_reset = grst_q;
  assign clear_status = cls_q;

  // Checks
  sequence s_evr_read;
    evreg_rd;
  endsequence
  sequence s_opc_pending;
    (st_q == ST_OPC_WAIT) && !evreg_q[EVR_OPC_BIT];
  endsequence

  a_read_clears: assert property (@(posedge clk) disable iff (!rst_n_q)
    s_evr_read |=> (rsp_data_q == $past(evreg_q)) && ((evreg_q & ~$past(set_bits)) == 8'h00))
    else $error("event read did not return and clear");
  a_opc_sets: assert property (@(posedge clk) disable iff (!rst_n_q)
    evt.op_done |=> evreg_q[EVR_OPC_BIT]) else $error("completion bit not set");
  a_unused_zero: assert property (@(posedge clk) disable iff (!rst_n_q)
    (evreg_q & ~EVR_USED_MASK) == 8'h00) else $error("unused event bit set");
  a_dde_sets: assert property (@(posedge clk) disable iff (!rst_n_q)
    evt.dev_err |=> evreg_q[EVR_DDE_BIT]) else $error("device error bit not set");
  a_exe_sets: assert property (@(posedge clk) disable iff (!rst_n_q)
    evt.exec_err |=> evreg_q[EVR_EXE_BIT]) else $error("execution error bit not set");
  a_cme_sets: assert property (@(posedge clk) disable iff (!rst_n_q)
    evt.cmd_err |=> evreg_q[EVR_CME_BIT]) else $error("command error bit not set");
  a_pon_seen: assert property (@(posedge clk)
    $rose(rst_n_q) |-> evreg_q[EVR_PON_BIT]) else $error("power-on bit missing after reset");
  a_mask_blocks: assert property (@(posedge clk) disable iff (!rst_n_q)
    ((evreg_q & ese_q) == 8'h00) |=> !esb_q && !srq_q) else $error("masked event raised summary");
  a_opc_clear: assert property (@(posedge clk) disable iff (!rst_n_q)
    (take && cmd.op == SESU_OPC_WR && !evt.op_done) |=> !evreg_q[EVR_OPC_BIT])
    else $error("completion command did not clear flag");
  a_opc_stall: assert property (@(posedge clk) disable iff (!rst_n_q)
    s_opc_pending |=> !rsp_valid_q ##0 !cmd_ready) else $error("completion query answered early");
  a_opc_answer: assert property (@(posedge clk) disable iff (!rst_n_q)
    (st_q == ST_OPC_WAIT && evreg_q[EVR_OPC_BIT]) |=> rsp_valid_q && rsp_data_q == OPC_ANSWER)
    else $error("completion query answer wrong");
  a_idn_first: assert property (@(posedge clk) disable iff (!rst_n_q)
    (take && cmd.op == SESU_IDN_RD) |=> rsp_valid_q && rsp_data_q == IDN_STR[8*IDN_LEN-1 -: 8])
    else $error("identification did not start");
  a_rst_strobe: assert property (@(posedge clk) disable iff (!rst_n_q)
    (take && cmd.op == SESU_RST) |=> global_reset ##1 (!global_reset || $past(take && cmd.op == SESU_RST)))
    else $error("global reset strobe wrong");
  a_esb_gate: assert property (@(posedge clk) disable iff (!rst_n_q)
    !sre_q[SRE_ESB_BIT] |=> !srq_q) else $error("request without summary enable");
  a_cls_clears: assert property (@(posedge clk) disable iff (!rst_n_q)
    (cls_cmd && set_bits == 8'h00) |=> evreg_q == 8'h00 && clear_status) else $error("clear status failed");
  a_bits_hold: assert property (@(posedge clk) disable iff (!rst_n_q)
    !(take && (cmd.op == SESU_EVR_RD || cmd.op == SESU_CLS || cmd.op == SESU_OPC_WR))
    |=> (evreg_q & $past(evreg_q)) == $past(evreg_q)) else $error("event bit lost");

endmodule

/* File: tb/sesu_host.sv */
/*
  Host controller model: sends decoded commands and takes answer bytes,
  either at once or stalled to one byte every fourth cycle.
  Assumes clk from the bench and a bench top named sesu_test.
*/
`timescale 1ns/1ps
module sesu_host (
  // Clock
  input  wire logic                clk,
  // Command port
  output logic                     cmd_valid = 1'b0,
  output sesu_pkg::sesu_cmd_t      cmd = '0,
  input  wire logic                cmd_ready,
  // Answer stream
  input  wire logic                rsp_valid,
  input  wire logic [7:0]          rsp_data,
  input  wire logic                rsp_last,
  output logic                     rsp_ready = 1'b1
);
  import sesu_pkg::*;
  logic       slow = 1'b0;   // Stall answers
  logic [1:0] cnt_q = 2'h0;  // Stall phase

  // Ready every cycle, or one cycle in four when stalling
  always @(posedge clk)
  begin
    cnt_q     <= cnt_q + 2'h1;
    rsp_ready <= !slow || cnt_q == 2'h3;
  end

  // One command, held until the unit takes it
  task automatic send(input sesu_op_t op, input logic [7:0] arg = 8'h00);
    int n = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd       <= '{op: op, arg: arg};
    @(negedge clk);
    while (!cmd_ready && n < 200)
    begin
      n++;
      @(negedge clk);
    end
    if (n == 200)
      sesu_test.hang();
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask

  // One answer byte, taken at the edge after it is seen
  task automatic recv(output logic [7:0] d, output logic l);
    int n = 0;
    @(negedge clk);
    while (!(rsp_valid && rsp_ready) && n < 200)
    begin
      n++;
      @(negedge clk);
    end
    if (n == 200)
      sesu_test.hang();
    d = rsp_data;
    l = rsp_last;
    @(posedge clk);
  endtask
endmodule

/* File: tb/sesu_test.sv */
/*
  Self-checking bench for the standard event status unit.
  Assumes the host model in sesu_host.sv and the unit's package.
*/
`timescale 1ns/1ps
module sesu_test;
  import sesu_pkg::*;
  logic       clk = 1'b0;      // 125 MHz clock
  logic       reset_n = 1'b0;  // Active low reset
  logic       cmd_valid;       // Command present
  sesu_cmd_t  cmd;             // Command
  logic       cmd_ready;       // Unit can take
  sesu_evt_t  evt = '0;        // Event pulses
  logic       rsp_valid;       // Answer byte valid
  logic [7:0] rsp_data;        // Answer byte
  logic       rsp_last;        // Final byte
  logic       rsp_ready;       // Host takes byte
  logic       srq;             // Service request
  logic       esb;             // Event summary
  logic       global_reset;    // Reset strobe
  logic       clear_status;    // Clear strobe
  int         error_cnt = 0;   // Mismatches
  int         n_checks = 0;    // Comparisons
  logic [7:0] d;               // Received byte
  logic       l;               // Received last flag
  logic [7:0] evt_val [4] = '{8'h01, 8'h08, 8'h10, 8'h20};  // Bit per source

  // Clock
  initial
    forever #4 clk = ~clk;

  sesu_top DUT (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .evt(evt), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_ready(rsp_ready),
    .srq(srq), .esb(esb), .global_reset(global_reset), .clear_status(clear_status));

  sesu_host host (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_last(rsp_last), .rsp_ready(rsp_ready));

  // Verdict and end of run
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // A wait ran out
  task automatic hang;
    error_cnt++;
    $display("Error handshake expected 1 seen 0");
    tally_and_finish();
  endtask

  // Compare one value
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Single-byte query and compare
  task automatic rd(input sesu_op_t op, input string nm, input logic [7:0] exp);
    host.send(op);
    host.recv(d, l);
    chk(nm, exp, d);
    chk("last", 8'h01, {7'h0, l});
  endtask

  // One-cycle event pulse, then time for the summary to settle
  task automatic pulse(input sesu_evt_t e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= '0;
    repeat (3) @(posedge clk);
  endtask

  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(SESU_EVR_RD, "evr_pon", EVR_RESET);
    rd(SESU_EVR_RD, "evr_clr", 8'h00);
    $display("test power_on done");
    // Each source sets its own bit, which outlives the pulse
    for (int i = 0; i < 4; i++)
    begin
      pulse(sesu_evt_t'(4'h8 >> i));
      rd(SESU_EVR_RD, "evr_evt", evt_val[i]);
    end
    pulse('1);
    rd(SESU_EVR_RD, "evr_all", 8'h39);
    $display("test events done");
    // Masking toward the service request
    host.send(SESU_ESE_WR, 8'h08);
    host.send(SESU_SRE_WR, 8'h20);
    rd(SESU_ESE_RD, "ese", 8'h08);
    rd(SESU_SRE_RD, "sre", 8'h20);
    pulse(4'h2);
    chk("srq_blk", 8'h00, {6'h0, esb, srq});
    pulse(4'h4);
    chk("srq_on", 8'h03, {6'h0, esb, srq});
    host.send(SESU_SRE_WR, 8'hdf);
    repeat (3) @(posedge clk);
    chk("srq_sre", 8'h02, {6'h0, esb, srq});
    rd(SESU_EVR_RD, "evr_msk", 8'h18);
    repeat (3) @(posedge clk);
    chk("srq_clr", 8'h00, {6'h0, esb, srq});
    $display("test mask done");
    // Completion: operate, clear, then block on the query
    host.send(SESU_ESE_WR, 8'h01);
    host.send(SESU_SRE_WR, 8'h20);
    pulse(4'h8);
    host.send(SESU_OPC_WR);
    host.send(SESU_OPC_RD);
    repeat (6) @(negedge clk);
    chk("opc_wait", 8'h00, {6'h0, rsp_valid, srq});
    host.slow = 1'b1;
    pulse(4'h8);
    host.recv(d, l);
    chk("opc_ans", OPC_ANSWER, d);
    chk("opc_srq", 8'h03, {6'h0, l, srq});
    $display("test completion done");
    // Identification, taken by a stalling host
    host.send(SESU_IDN_RD);
    for (int i = IDN_LEN - 1; i >= 0; i--)
    begin
      host.recv(d, l);
      chk("idn", IDN_STR[8*i +: 8], d);
      chk("idn_last", {7'h0, i == 0}, {7'h0, l});
    end
    @(negedge clk);
    host.slow = 1'b0;
    $display("test identity done");
    // Global reset and clear status strobes
    pulse(4'h1);
    host.send(SESU_RST);
    @(negedge clk);
    chk("rst_on", 8'h01, {7'h0, global_reset});
    @(negedge clk);
    chk("rst_off", 8'h00, {7'h0, global_reset});
    host.send(SESU_CLS);
    @(negedge clk);
    chk("cls_on", 8'h01, {7'h0, clear_status});
    rd(SESU_EVR_RD, "evr_cls", 8'h00);
    $display("test strobes done");
    tally_and_finish();
  end
endmodule
